/* File: verilog/tcr_cfg.svh */
// constants of the torque control reference block
// assumes: included by the top module only
`ifndef TCR_CFG_SVH
`define TCR_CFG_SVH
// clock, timing and percentage limits
`define TCR_CLK_NS     8
`define TCR_MS_NS      1000000
`define TCR_MAX_MS     10'd1000
`define TCR_MAX_PCT    7'd120
`define TCR_PCT_FULL   100
// register byte offsets
`define TCR_OFS_CFG    8'h00
`define TCR_OFS_TIME   8'h04
`define TCR_OFS_SPD    8'h08
`define TCR_OFS_TLIM   8'h0c
`define TCR_OFS_BIAS   8'h10
`define TCR_OFS_STAT   8'h14
`define TCR_OFS_ISTAT  8'h18
`define TCR_OFS_ICLR   8'h1c
`define TCR_OFS_IEN    8'h20
`define TCR_OFS_MON    8'h24
// reset values
`define TCR_RST_CFG    32'h0000_0010
`define TCR_RST_TIME   32'h0000_0000
`define TCR_RST_SPD    32'h0000_0a0a
`define TCR_RST_TLIM   32'h7fff_7fff
`define TCR_RST_BIAS   32'h0000_0000
// method, function and source codes
`define TCR_M_CLV      3'd3
`define TCR_M_PMCLV    3'd5
`define TCR_M_CLTRQ    3'd6
`define TCR_FN_SWITCH  8'd70
`define TCR_FN_TRQ     8'd15
`define TCR_FN_COMP    8'd16
`define TCR_FN_NONE    8'd0
`define TCR_LS_FREQ    2'd1
`define TCR_LS_PCT     2'd2
// event bit positions
`define TCR_EV_DUP     0
`define TCR_EV_MODE    1
`define TCR_EV_CLAMP   2
`define TCR_EV_N       3
`endif

/* File: verilog/tcr_pkg.sv */
// types of the torque control reference block
// assumes: nothing beyond the constants header
package tcr_pkg;
    typedef enum logic [1:0] {
        TCR_SPEED  = 2'b01,
        TCR_TORQUE = 2'b10
    } tcr_mode_t;
endpackage : tcr_pkg

/* File: verilog/tcr_top.sv */
// torque control reference path with apb register file
// assumes: one clock pclk, all inputs synchronous to it, apb master outside
`timescale 1ns/10ps
`default_nettype none
`include "tcr_cfg.svh"
module tcr_top #(
    parameter int DW     = 16,
    parameter int MS_CYC = `TCR_MS_NS / `TCR_CLK_NS
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // drive side inputs
    input  wire logic signed [DW-1:0] analog_in1,
    input  wire logic signed [DW-1:0] analog_in2,
    input  wire logic signed [DW-1:0] freq_cmd,
    input  wire logic signed [DW-1:0] speed_fb,
    input  wire logic [DW-1:0]        max_freq,
    input  wire logic                 spd_trq_sel,
    // drive side outputs
    output logic signed [DW-1:0]      internal_torque_monitor,
    output logic signed [DW-1:0]      speed_ref,
    output logic                      torque_mode,
    output logic                      dir_reverse,
    output logic                      irq
);
    import tcr_pkg::*;

    // the negative limit sits at bit 16 and the gain shift at bits 19:16
    if (DW < 12 || DW > 16) begin : g_bad_dw
        $error("tcr_top: DW must lie in 12..16");
    end
    if (MS_CYC < 1) begin : g_bad_ms
        $error("tcr_top: MS_CYC must be at least 1");
    end

    localparam int XW = DW + 4;
    localparam logic signed [XW-1:0] XMAX = XW'((1 <<< (DW - 1)) - 1);

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] wmask(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmask

    function automatic logic signed [XW-1:0] clip(
            input logic signed [XW-1:0] v,
            input logic signed [XW-1:0] lo,
            input logic signed [XW-1:0] hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction : clip

    function automatic logic signed [XW-1:0] ext(input logic signed [DW-1:0] v);
        return XW'(v);
    endfunction : ext

    function automatic logic signed [XW-1:0] pct_of(input logic [6:0] p,
                                                   input logic [DW-1:0] m);
        logic [DW+7:0] prod;
        prod = m * p;
        return XW'(prod / `TCR_PCT_FULL);
    endfunction : pct_of

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cfg_r, cfg_nxt, time_r, time_nxt, spd_r, spd_nxt;
    logic [31:0] tlim_r, tlim_nxt, bias_r, bias_nxt;
    logic [`TCR_EV_N-1:0] ist_r, ist_nxt, ien_r, ien_nxt, ev;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic        dup_r, dup_nxt;

    logic [2:0]  control_method_select;
    logic [1:0]  speed_limit_source;
    logic [7:0]  multi_function_input_select;
    logic [7:0]  analog_in1_function, analog_in2_function;
    logic [9:0]  torque_filter_time, control_switch_delay;
    logic [6:0]  forward_speed_limit, reverse_speed_limit;
    logic [DW-1:0] tlim_pos, tlim_neg, lim_bias;
    logic [3:0]  comp_shift;

    assign control_method_select       = cfg_r[2:0];
    assign speed_limit_source          = cfg_r[5:4];
    assign multi_function_input_select = cfg_r[15:8];
    assign analog_in1_function         = cfg_r[23:16];
    assign analog_in2_function         = cfg_r[31:24];
    assign torque_filter_time          = time_r[9:0];
    assign control_switch_delay        = time_r[25:16];
    assign forward_speed_limit         = spd_r[6:0];
    assign reverse_speed_limit         = spd_r[14:8];
    assign tlim_pos                    = tlim_r[DW-1:0];
    assign tlim_neg                    = tlim_r[16 +: DW];
    assign lim_bias                    = bias_r[DW-1:0];
    assign comp_shift                  = bias_r[19:16];

    ////////////////////////////////////////////////////////////////////
    // drive state
    tcr_mode_t   mode_r, mode_nxt;
    logic        sel_r, sel_nxt, pend_r, pend_nxt;
    logic [9:0]  dly_r, dly_nxt;
    logic [$clog2(MS_CYC+1)-1:0] tick_cnt_r, tick_cnt_nxt;
    logic        tick;
    logic signed [DW-1:0] filt_r, filt_nxt;
    logic signed [DW-1:0] trq_out_r, trq_out_nxt, spd_out_r, spd_out_nxt;
    logic        dir_r, dir_nxt, irq_r, irq_nxt, clamp_r, clamp_nxt;

    logic        sw_ok, trq_en, in_torque;
    logic signed [DW-1:0] trq_src, comp_src;
    logic signed [XW-1:0] lim_f, lim_r, marg_f, marg_r, comp, sum, lo, hi;
    logic signed [XW-1:0] clamped, fstep;

    ////////////////////////////////////////////////////////////////////
    // mode selection and changeover delay
    always_comb begin
        sw_ok = (control_method_select == `TCR_M_CLV ||
                 control_method_select == `TCR_M_PMCLV) &&
                multi_function_input_select == `TCR_FN_SWITCH;
        trq_en = control_method_select == `TCR_M_CLTRQ || sw_ok;
        tick = tick_cnt_r == ($bits(tick_cnt_r))'(MS_CYC - 1);
        tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
        sel_nxt = spd_trq_sel;
        pend_nxt = pend_r;
        dly_nxt = dly_r;
        mode_nxt = mode_r;
        if (!trq_en) begin
            mode_nxt = TCR_SPEED;
            pend_nxt = 1'b0;
        end else if (!sw_ok) begin
            mode_nxt = TCR_TORQUE;
            pend_nxt = 1'b0;
        end else if (sel_r != spd_trq_sel ||
                     (!pend_r && (mode_r == TCR_TORQUE) != sel_r)) begin
            // entering switch mode with the select already set also starts a delay
            pend_nxt = 1'b1;
            dly_nxt = control_switch_delay;
            // prescaler restart: whole ms delay, filter step slips under one ms
            tick_cnt_nxt = '0;
        end else if (pend_r) begin
            if (dly_r == '0) begin
                pend_nxt = 1'b0;
                mode_nxt = sel_r ? TCR_TORQUE : TCR_SPEED;
            end else if (tick) begin
                dly_nxt = dly_r - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= TCR_SPEED;
            sel_r <= 1'b0;
            pend_r <= 1'b0;
            dly_r <= '0;
            tick_cnt_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            sel_r <= sel_nxt;
            pend_r <= pend_nxt;
            dly_r <= dly_nxt;
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // torque path
    always_comb begin
        in_torque = mode_r == TCR_TORQUE;
        trq_src = '0;
        comp_src = '0;
        if (analog_in1_function == `TCR_FN_TRQ) begin
            trq_src = analog_in1;
        end else if (analog_in2_function == `TCR_FN_TRQ) begin
            trq_src = analog_in2;
        end
        if (analog_in1_function == `TCR_FN_COMP) begin
            comp_src = analog_in1;
        end else if (analog_in2_function == `TCR_FN_COMP) begin
            comp_src = analog_in2;
        end
        // first order lag, one step per ms
        fstep = (ext(trq_src) - ext(filt_r)) /
                $signed({{(XW-11){1'b0}}, torque_filter_time, 1'b0} >>> 1);
        filt_nxt = filt_r;
        if (torque_filter_time == '0) begin
            filt_nxt = trq_src;
        end else if (tick) begin
            filt_nxt = DW'(ext(filt_r) + fstep);
        end
        if (speed_limit_source == `TCR_LS_PCT) begin
            lim_f = pct_of(forward_speed_limit, max_freq);
            lim_r = pct_of(reverse_speed_limit, max_freq);
        end else begin
            // frequency command arrives already ramped and s-curved
            lim_f = freq_cmd < 0 ? -ext(freq_cmd) : ext(freq_cmd);
            lim_r = lim_f;
        end
        marg_f = lim_f - ext(speed_fb);
        marg_r = lim_r + ext(speed_fb);
        comp = '0;
        if (marg_f < ext(lim_bias)) begin
            comp = -((ext(lim_bias) - marg_f) <<< comp_shift);
        end else if (marg_r < ext(lim_bias)) begin
            comp = (ext(lim_bias) - marg_r) <<< comp_shift;
        end
        comp = clip(comp, -XMAX, XMAX);
        sum = ext(filt_r) + comp + ext(comp_src);
        hi = XW'(tlim_pos);
        lo = -XW'(tlim_neg);
        clamped = clip(sum, lo, hi);
        clamp_nxt = in_torque && (sum > hi || sum < lo);
        if (in_torque) begin
            trq_out_nxt = DW'(clamped);
            spd_out_nxt = freq_cmd;
            dir_nxt = trq_src < 0;
        end else begin
            trq_out_nxt = tlim_pos;
            spd_out_nxt = freq_cmd;
            dir_nxt = freq_cmd < 0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_r <= '0;
            trq_out_r <= '0;
            spd_out_r <= '0;
            dir_r <= 1'b0;
            clamp_r <= 1'b0;
        end else begin
            filt_r <= filt_nxt;
            trq_out_r <= trq_out_nxt;
            spd_out_r <= spd_out_nxt;
            dir_r <= dir_nxt;
            clamp_r <= clamp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave, no wait states: read data built in the setup cycle
    logic        setup, access, wr;
    logic [31:0] cfg_w;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable && pready_r;
        wr = access && pwrite;
        cfg_nxt = cfg_r;
        time_nxt = time_r;
        spd_nxt = spd_r;
        tlim_nxt = tlim_r;
        bias_nxt = bias_r;
        ien_nxt = ien_r;
        dup_nxt = 1'b0;
        ev = '0;
        cfg_w = wmask(cfg_r, pwdata, pstrb);
        if (wr && paddr == `TCR_OFS_CFG) begin
            if (cfg_w[23:16] == cfg_w[31:24] &&
                cfg_w[23:16] != `TCR_FN_NONE) begin
                dup_nxt = 1'b1;
            end else begin
                cfg_nxt = cfg_w;
            end
        end else if (wr && paddr == `TCR_OFS_TIME) begin
            time_nxt = wmask(time_r, pwdata, pstrb);
            if (time_nxt[9:0] > `TCR_MAX_MS) begin
                time_nxt[9:0] = `TCR_MAX_MS;
            end
            if (time_nxt[25:16] > `TCR_MAX_MS) begin
                time_nxt[25:16] = `TCR_MAX_MS;
            end
            time_nxt[31:26] = '0;
            time_nxt[15:10] = '0;
        end else if (wr && paddr == `TCR_OFS_SPD) begin
            spd_nxt = wmask(spd_r, pwdata, pstrb) & 32'h0000_7f7f;
            if (spd_nxt[6:0] > `TCR_MAX_PCT) begin
                spd_nxt[6:0] = `TCR_MAX_PCT;
            end
            if (spd_nxt[14:8] > `TCR_MAX_PCT) begin
                spd_nxt[14:8] = `TCR_MAX_PCT;
            end
        end else if (wr && paddr == `TCR_OFS_TLIM) begin
            tlim_nxt = wmask(tlim_r, pwdata, pstrb);
        end else if (wr && paddr == `TCR_OFS_BIAS) begin
            bias_nxt = wmask(bias_r, pwdata, pstrb);
        end else if (wr && paddr == `TCR_OFS_IEN) begin
            ien_nxt = pwdata[`TCR_EV_N-1:0];
        end
        ev[`TCR_EV_DUP] = dup_r;
        ev[`TCR_EV_MODE] = mode_nxt != mode_r;
        ev[`TCR_EV_CLAMP] = clamp_nxt && !clamp_r;
        // a new event wins over a clear in the same cycle
        ist_nxt = ist_r;
        if (wr && paddr == `TCR_OFS_ICLR) begin
            ist_nxt = ist_r & ~pwdata[`TCR_EV_N-1:0];
        end
        ist_nxt = ist_nxt | ev;
        irq_nxt = |(ist_nxt & ien_nxt);
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = '0;
            if (paddr == `TCR_OFS_CFG) begin
                prdata_nxt = cfg_r;
            end else if (paddr == `TCR_OFS_TIME) begin
                prdata_nxt = time_r;
            end else if (paddr == `TCR_OFS_SPD) begin
                prdata_nxt = spd_r;
            end else if (paddr == `TCR_OFS_TLIM) begin
                prdata_nxt = tlim_r;
            end else if (paddr == `TCR_OFS_BIAS) begin
                prdata_nxt = bias_r;
            end else if (paddr == `TCR_OFS_STAT) begin
                prdata_nxt = {26'h0, pend_r, dir_r, clamp_r,
                              sw_ok, trq_en, mode_r == TCR_TORQUE};
            end else if (paddr == `TCR_OFS_ISTAT) begin
                prdata_nxt = 32'(ist_r);
            end else if (paddr == `TCR_OFS_ICLR) begin
                prdata_nxt = '0;
            end else if (paddr == `TCR_OFS_IEN) begin
                prdata_nxt = 32'(ien_r);
            end else if (paddr == `TCR_OFS_MON) begin
                prdata_nxt = 32'(trq_out_r);
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= `TCR_RST_CFG;
            time_r <= `TCR_RST_TIME;
            spd_r <= `TCR_RST_SPD;
            tlim_r <= `TCR_RST_TLIM;
            bias_r <= `TCR_RST_BIAS;
            ist_r <= '0;
            ien_r <= '0;
            dup_r <= 1'b0;
            irq_r <= 1'b0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            time_r <= time_nxt;
            spd_r <= spd_nxt;
            tlim_r <= tlim_nxt;
            bias_r <= bias_nxt;
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            dup_r <= dup_nxt;
            irq_r <= irq_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign internal_torque_monitor = trq_out_r;
    assign speed_ref = spd_out_r;
    assign torque_mode = mode_r == TCR_TORQUE;
    assign dir_reverse = dir_r;
    assign irq = irq_r;
endmodule : tcr_top
`default_nettype wire

/* File: bench/tcr_motor.sv */
// motor model: speed feedback that follows a target promptly or slowly
// assumes: same clock and reset as the block, target set by the bench
`timescale 1ns/10ps
`default_nettype none
module tcr_motor (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // target and pace
    input  wire logic signed [15:0] fb_target,
    input  wire logic               slow,
    // feedback
    output logic signed [15:0]      speed_fb
);
    logic signed [15:0] fb_r;
    logic signed [15:0] fb_nxt;
    // slow pace steps one unit a cycle, like a loaded shaft
    always_comb begin
        fb_nxt = fb_target;
        if (slow && fb_target > fb_r) begin
            fb_nxt = fb_r + 16'sd1;
        end else if (slow && fb_target < fb_r) begin
            fb_nxt = fb_r - 16'sd1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_r <= 16'sd0;
        end else begin
            fb_r <= fb_nxt;
        end
    end
    assign speed_fb = fb_r;
endmodule : tcr_motor
`default_nettype wire

/* File: bench/tcr_top_assertions.sv */
// checker for the torque control reference top
// assumes: full-word writes to the limit register, one clock domain
`timescale 1ns/10ps
`default_nettype none
module tcr_chk #(
    parameter int DW = 16
) (
    // clock and apb
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic [7:0]           paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // drive side
    input wire logic signed [DW-1:0] freq_cmd,
    input wire logic signed [DW-1:0] internal_torque_monitor,
    input wire logic signed [DW-1:0] speed_ref,
    input wire logic                 torque_mode,
    input wire logic                 dir_reverse
);
    logic [31:0] lim_r;
    logic [31:0] lim_nxt;
    logic [1:0]  age_r;
    logic [1:0]  age_nxt;
    logic        lim_wr;
    assign lim_wr = psel && penable && pready && pwrite && paddr == 8'h0c;
    // shadow of the torque limits and cycles since they were written
    always_comb begin
        lim_nxt = lim_wr ? pwdata : lim_r;
        age_nxt = lim_wr ? 2'h0 : ((age_r == 2'h3) ? age_r : age_r + 2'h1);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_r <= 32'h7fff_7fff;
            age_r <= 2'h0;
        end else begin
            lim_r <= lim_nxt;
            age_r <= age_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence acc_s;
        psel && penable && pready;
    endsequence
    apb_ready_a: assert property (setup_s |=> acc_s) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    err_pair_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_err_a: assert property (acc_s ##0 paddr > 8'h24 |-> pslverr)
        else $error("unmapped access accepted");
    unmapped_zero_a: assert property (acc_s ##0 (paddr > 8'h24 && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    speed_follow_a: assert property ($past(presetn) |-> speed_ref == $past(freq_cmd))
        else $error("speed reference lag wrong");
    dir_speed_a: assert property (!torque_mode && !$past(torque_mode) && $past(presetn)
        |-> dir_reverse == $past(freq_cmd[DW-1])) else $error("direction wrong");
    spd_mon_a: assert property (!torque_mode && !$past(torque_mode) && age_r == 2'h3
        |-> internal_torque_monitor == $signed(lim_r[DW-1:0])) else $error("monitor not limit");
    trq_clamp_a: assert property (torque_mode && $past(torque_mode) && age_r == 2'h3
        |-> internal_torque_monitor <= $signed(lim_r[DW-1:0])
        && internal_torque_monitor >= -$signed(lim_r[16+:DW])) else $error("clamp broken");
endmodule : tcr_chk
bind tcr_top tcr_chk #(.DW(DW)) u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .freq_cmd(freq_cmd), .speed_ref(speed_ref),
    .internal_torque_monitor(internal_torque_monitor), .torque_mode(torque_mode),
    .dir_reverse(dir_reverse));
`default_nettype wire

/* File: bench/torque_control_reference_tb.sv */
// self-checking bench of the torque control reference top
// assumes: apb master and motor model here, ms tick shortened to 4 cycles
`timescale 1ns/10ps
`default_nettype none
module torque_control_reference_tb;
    import tcr_pkg::*;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic [7:0]         paddr = 8'h0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [31:0]        pwdata = 32'h0;
    logic [3:0]         pstrb = 4'hf;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic signed [15:0] analog_in1 = 16'sh0;
    logic signed [15:0] analog_in2 = 16'sh0;
    logic signed [15:0] freq_cmd = 16'sh0;
    logic signed [15:0] speed_fb;
    logic [15:0]        max_freq = 16'd1000;
    logic               spd_trq_sel = 1'b0;
    logic signed [15:0] fb_target = 16'sh0;
    logic               slow = 1'b0;
    logic signed [15:0] internal_torque_monitor;
    logic signed [15:0] speed_ref;
    logic               torque_mode;
    logic               dir_reverse;
    logic               irq;
    int                 fail_count = 0;
    int                 num_checks = 0;
    always #4 pclk = ~pclk;
    tcr_top #(.DW(16), .MS_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_in1(analog_in1),
        .analog_in2(analog_in2), .freq_cmd(freq_cmd), .speed_fb(speed_fb),
        .max_freq(max_freq), .spd_trq_sel(spd_trq_sel),
        .internal_torque_monitor(internal_torque_monitor), .speed_ref(speed_ref),
        .torque_mode(torque_mode), .dir_reverse(dir_reverse), .irq(irq));
    tcr_motor u_motor (.pclk(pclk), .presetn(presetn), .fb_target(fb_target),
        .slow(slow), .speed_fb(speed_fb));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
    endtask : rdchk
    task automatic step(input logic [15:0] a, b, t, x, input int n);
        analog_in1 <= a;
        analog_in2 <= b;
        fb_target <= t;
        repeat (n) @(posedge pclk);
        chk({16'h0, internal_torque_monitor}, {16'h0, x});
    endtask : step
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0]  a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h40};
        logic [31:0] v [7] = '{32'h10, 32'h0, 32'h0a0a, 32'h7fff_7fff, 32'h0, 32'h0, 32'h0};
        logic [31:0] q;
        logic        e;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, a[i], 32'h0, q, e);
            chk(q, v[i]);
            chk({31'h0, e}, {31'h0, i == 6});
        end
    endtask : t_regs
    task automatic t_dup;
        wr(8'h20, 32'h1);
        wr(8'h00, 32'h0f0f_0000);
        rdchk(8'h00, 32'h10);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdchk(8'h18, 32'h1);
        wr(8'h20, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h20, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h1c, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(8'h18, 32'h0);
    endtask : t_dup
    task automatic t_modes;
        logic [2:0] m [5] = '{3'd0, 3'd3, 3'd5, 3'd6, 3'd3};
        logic [7:0] f [5] = '{8'h46, 8'h46, 8'h46, 8'h00, 8'h00};
        logic       x [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        freq_cmd <= -16'sd5;
        spd_trq_sel <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, {16'h0, f[i], 5'h02, m[i]});
            repeat (12) @(posedge pclk);
            chk({31'h0, torque_mode}, {31'h0, x[i]});
        end
        chk({31'h0, dir_reverse}, 32'h1);
    endtask : t_modes
    task automatic t_delay;
        int n;
        spd_trq_sel <= 1'b0;
        wr(8'h04, 32'h0001_0000);
        wr(8'h00, 32'h0000_4613);
        repeat (12) @(posedge pclk);
        spd_trq_sel <= 1'b1;
        repeat (3) @(posedge pclk);
        spd_trq_sel <= 1'b0;
        repeat (14) @(posedge pclk);
        chk({31'h0, torque_mode}, 32'h0);
        // a glitch shorter than the delay restarts the count from its last edge
        spd_trq_sel <= 1'b1;
        repeat (3) @(posedge pclk);
        spd_trq_sel <= 1'b0;
        @(posedge pclk);
        spd_trq_sel <= 1'b1;
        n = 0;
        while (torque_mode !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk(n, 32'd7);
    endtask : t_delay
    task automatic t_torque;
        wr(8'h04, 32'h0);
        wr(8'h0c, 32'h0800_1000);
        wr(8'h00, 32'h100f_0026);
        step(16'h4000, 16'h0, 16'h0, 16'h1000, 8);
        chk({31'h0, dir_reverse}, 32'h0);
        step(16'hc000, 16'h0, 16'h0, 16'hf800, 8);
        chk({31'h0, dir_reverse}, 32'h1);
        step(16'h0400, 16'h0100, 16'h0, 16'h0500, 8);
        slow <= 1'b1;
        step(16'h0400, 16'h0100, 16'd200, 16'h049c, 260);
        slow <= 1'b0;
        wr(8'h00, 32'h100f_0016);
        freq_cmd <= 16'sd300;
        step(16'h0400, 16'h0100, 16'd200, 16'h0500, 8);
        wr(8'h00, 32'h100f_0026);
        wr(8'h08, 32'h0000_0a78);
        step(16'h0400, 16'h0100, 16'd1250, 16'h04ce, 8);
        step(16'h0400, 16'h0100, -16'sd150, 16'h0532, 8);
        // a 2 ms lag halves the gap each ms and stalls one short of the source
        wr(8'h04, 32'h0000_0002);
        step(16'h0800, 16'h0100, -16'sd150, 16'h0931, 100);
        rdchk(8'h18, 32'h6);
        wr(8'h04, 32'h03ff_03ff);
        rdchk(8'h04, 32'h03e8_03e8);
        wr(8'h08, 32'h0000_7f7f);
        rdchk(8'h08, 32'h0000_7878);
    endtask : t_torque
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_dup();
        t_modes();
        t_delay();
        t_torque();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        summarize();
    end
endmodule : torque_control_reference_tb
`default_nettype wire
